//--- rtl/host_processor_port.sv
`timescale 1ns/1ps
module host_processor_port
    import host_port_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    input  wire logic              i_device_reset_n,
    input  wire logic              i_bus_style_select,
    input  wire logic              i_narrow_bus_select,
    input  wire logic              i_cs_n,
    input  wire logic              i_data_strobe_n,
    input  wire logic              i_rw,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [1:0]        i_xfer_width_lines,
    input  wire logic [DATA_W-1:0] i_data,
    output logic      [DATA_W-1:0] o_data,
    output logic                   o_data_oe_n,
    output logic                   o_transfer_ack_n,
    output logic                   o_transfer_ack_oe_n,
    output logic                   o_bus_error_n,
    output logic                   o_bus_error_oe_n,
    output logic                   o_wait_n,
    output logic                   o_wait_oe_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   o_irq,
    output logic                   o_msg_valid,
    output logic      [CMEM_AW-1:0] o_msg_channel,
    output logic      [MSG_W-1:0]  o_msg_data
);

    // ----------------------------------------------------------------
    // Reset: device pin clears asynchronously, release is synchronised
    // ----------------------------------------------------------------
    logic        dev_rst_meta;
    logic        dev_rst_sync;
    logic        core_rst;

    always_ff @(posedge i_clk or negedge i_device_reset_n)
    begin
        if (!i_device_reset_n)
        begin
            dev_rst_meta <= 1'b0;
            dev_rst_sync <= 1'b0;
        end
        else
        begin
            dev_rst_meta <= 1'b1;
            dev_rst_sync <= dev_rst_meta;
        end
    end

    assign core_rst = !i_reset_n || !dev_rst_sync;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Address, data and size must settle before the strobe falls, since
    // the bits cross independently and only the strobe is qualified.
    logic [SYNC_W-1:0] pins_sync;
    logic              s_style;
    logic              s_narrow;
    logic              s_cs_n;
    logic              s_ds_n;
    logic              s_rw;
    logic [ADDR_W-1:0] s_addr;
    logic [1:0]        s_size;
    logic [DATA_W-1:0] s_data;

    pin_sync #(.WIDTH(SYNC_W)) u_sync (
        .i_clk  (i_clk),
        .i_pin  ({i_bus_style_select, i_narrow_bus_select, i_cs_n,
                  i_data_strobe_n, i_rw, i_addr, i_xfer_width_lines,
                  i_data}),
        .o_sync (pins_sync)
    );

    assign {s_style, s_narrow, s_cs_n, s_ds_n, s_rw, s_addr, s_size,
            s_data} = pins_sync;

    // ----------------------------------------------------------------
    // Byte lane and address decode
    // ----------------------------------------------------------------
    lane_if lanes ();
    assign lanes.style      = s_style;
    assign lanes.narrow     = s_narrow;
    assign lanes.size_lines = s_size;
    assign lanes.addr_low   = s_addr[1:0];

    lane_decode u_lanes (
        .lanes (lanes)
    );

    logic [WORD_W-1:0] word_idx;
    logic              hit_ctrl;
    logic              hit_status;
    logic              hit_scratch;
    logic              hit_cmem;
    logic              addr_valid;
    logic              access_req;
    logic [DATA_W-1:0] wr_data;
    logic [DATA_W-1:0] lane_mask;

    // A0 is ignored in 16-bit mode; A1 then picks the half word
    assign word_idx    = s_addr[ADDR_W-1:2];
    assign hit_ctrl    = (word_idx == HOST_CTRL_WORD);
    assign hit_status  = (word_idx == HOST_STATUS_WORD);
    assign hit_scratch = (word_idx == HOST_SCRATCH_WORD);
    assign hit_cmem    = (word_idx >= CMEM_BASE_WORD) &&
                         (word_idx < CMEM_BASE_WORD + WORD_W'(CMEM_DEPTH));
    assign addr_valid  = hit_ctrl || hit_status || hit_scratch || hit_cmem;
    assign access_req  = !s_cs_n && !s_ds_n;
    assign wr_data     = (s_narrow != WIDTH_32) ?
                         {s_data[15:0], s_data[15:0]} : s_data;

    for (genvar b = 0; b < 4; b++)
    begin : g_lane
        assign lane_mask[8*b +: 8] = {8{lanes.lane_en[b]}};
    end

    // ----------------------------------------------------------------
    // Storage: control, scratch and connection memory
    // ----------------------------------------------------------------
    logic [31:0]        ctrl;
    logic [31:0]        scratch;
    logic [DATA_W-1:0]  cmem [CMEM_DEPTH];
    logic [CMEM_AW-1:0] cmem_idx;
    logic [DATA_W-1:0]  cmem_rd;
    logic [31:0]        host_status;
    logic [DATA_W-1:0]  host_rd_word;
    logic [DATA_W-1:0]  host_rd_lanes;
    logic               host_wr_en;
    logic               apb_wr_en;
    logic               apb_rd_en;

    assign cmem_idx    = s_addr[CMEM_AW+1:2];
    assign cmem_rd     = cmem[cmem_idx];
    assign host_status = {29'h0, s_narrow, s_style,
                          ctrl[CTRL_MSG_EN_BIT]};
    assign host_rd_word = hit_ctrl    ? ctrl        :
                          hit_status  ? host_status :
                          hit_scratch ? scratch     :
                          hit_cmem    ? cmem_rd     : 32'h00000000;
    // Narrow reads put the selected half on D15-0
    assign host_rd_lanes = (s_narrow != WIDTH_32) ?
                           (s_addr[1] ? {16'h0, host_rd_word[31:16]} :
                                        {16'h0, host_rd_word[15:0]}) :
                           host_rd_word;

    // ----------------------------------------------------------------
    // Host access state machine
    // ----------------------------------------------------------------
    host_state_t state;
    host_state_t next_state;
    logic        acc_err;
    logic        host_rd_done;

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (access_req)
                    next_state = ST_ACCESS;
            ST_ACCESS:
                next_state = ST_RESPOND;
            ST_RESPOND:
                if (!access_req)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    // One cycle in ACCESS does the transfer; strobes must stay low
    assign host_wr_en   = (state == ST_ACCESS) && !s_rw && addr_valid;
    assign host_rd_done = (state == ST_ACCESS) && s_rw && addr_valid;

    always_ff @(posedge i_clk)
    begin
        if (core_rst)
        begin
            state   <= ST_IDLE;
            acc_err <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (state == ST_ACCESS)
                acc_err <= !addr_valid;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (core_rst)
            scratch <= 32'h00000000;
        else if (host_wr_en && hit_scratch)
            scratch <= (scratch & ~lane_mask) | (wr_data & lane_mask);
    end

    always_ff @(posedge i_clk)
    begin
        if (host_wr_en && hit_cmem)
            cmem[cmem_idx] <= (cmem_rd & ~lane_mask) |
                              (wr_data & lane_mask);
    end

    // APB write wins over a host write landing in the same cycle
    always_ff @(posedge i_clk)
    begin
        if (core_rst)
            ctrl <= CTRL_RESET;
        else if (apb_wr_en && paddr == APB_CTRL)
            ctrl <= pwdata;
        else if (host_wr_en && hit_ctrl)
            ctrl <= (ctrl & ~lane_mask) | (wr_data & lane_mask);
    end

    // ----------------------------------------------------------------
    // Host pin drivers, all from flops
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (core_rst)
        begin
            o_data              <= 32'h00000000;
            o_data_oe_n         <= 1'b1;
            o_transfer_ack_n    <= 1'b1;
            o_transfer_ack_oe_n <= 1'b1;
            o_bus_error_n       <= 1'b1;
            o_bus_error_oe_n    <= 1'b1;
            o_wait_n            <= 1'b1;
            o_wait_oe_n         <= 1'b1;
        end
        else
        begin
            if (state == ST_ACCESS && s_rw)
                o_data <= host_rd_lanes;
            o_data_oe_n <= !(next_state == ST_RESPOND && s_rw);
            o_transfer_ack_oe_n <= !(s_style == STYLE_STROBE &&
                                     next_state != ST_IDLE);
            o_transfer_ack_n <= !(next_state == ST_RESPOND &&
                                  (state == ST_ACCESS ? addr_valid
                                                      : !acc_err));
            o_bus_error_oe_n <= (next_state == ST_IDLE);
            o_bus_error_n    <= !(next_state == ST_RESPOND &&
                                  (state == ST_ACCESS ? !addr_valid
                                                      : acc_err));
            o_wait_oe_n <= !(s_style != STYLE_STROBE &&
                             next_state != ST_IDLE);
            o_wait_n    <= (next_state != ST_ACCESS);
        end
    end

    // ----------------------------------------------------------------
    // Message output scan over connection memory
    // ----------------------------------------------------------------
    // Scans one channel per clock; a host write to the channel being
    // read shows on the next pass, never as a torn word.
    logic [CMEM_AW-1:0] scan_ch;
    logic [DATA_W-1:0]  scan_word;

    assign scan_word = cmem[scan_ch];

    always_ff @(posedge i_clk)
    begin
        if (core_rst)
        begin
            scan_ch       <= '0;
            o_msg_valid   <= 1'b0;
            o_msg_channel <= '0;
            o_msg_data    <= '0;
        end
        else
        begin
            scan_ch       <= scan_ch + 1'b1;
            o_msg_channel <= scan_ch;
            o_msg_data    <= scan_word[MSG_W-1:0];
            o_msg_valid   <= ctrl[CTRL_MSG_EN_BIT] &&
                             scan_word[MSG_EN_BIT];
        end
    end

    // ----------------------------------------------------------------
    // APB slave, one wait state
    // ----------------------------------------------------------------
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_clear;
    logic             apb_hit;
    logic [31:0]      apb_rd_mux;
    logic             apb_first;

    assign apb_first = psel && penable && !pready;
    assign apb_wr_en = psel && penable && pready && pwrite;
    assign apb_rd_en = apb_first && !pwrite;
    assign apb_hit   = (paddr == APB_CTRL) || (paddr == APB_STATUS) ||
                       (paddr == APB_IRQ_STATUS) || (paddr == APB_IRQ_MASK);
    assign apb_rd_mux =
        (paddr == APB_CTRL)       ? ctrl :
        (paddr == APB_STATUS)     ? {28'h0, state == ST_IDLE ? 1'b0 : 1'b1,
                                     host_status[2:0]} :
        (paddr == APB_IRQ_STATUS) ? {29'h0, irq_status} :
        (paddr == APB_IRQ_MASK)   ? {29'h0, irq_mask} : 32'h00000000;

    always_ff @(posedge i_clk)
    begin
        if (core_rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= apb_first;
            pslverr <= apb_first && !apb_hit;
            if (apb_rd_en)
                prdata <= apb_rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // Interrupts: sticky, write one to clear, set wins
    // ----------------------------------------------------------------
    assign irq_event[IRQ_WR_BIT]   = host_wr_en;
    assign irq_event[IRQ_RD_BIT]   = host_rd_done;
    assign irq_event[IRQ_BUS_ERROR_N_BIT] = (state == ST_ACCESS) && !addr_valid;
    assign irq_clear = (apb_wr_en && paddr == APB_IRQ_STATUS) ?
                       pwdata[IRQ_W-1:0] : '0;

    always_ff @(posedge i_clk)
    begin
        if (core_rst)
        begin
            irq_status <= '0;
            irq_mask   <= '0;
            o_irq      <= 1'b0;
        end
        else
        begin
            irq_status <= (irq_status & ~irq_clear) | irq_event;
            if (apb_wr_en && paddr == APB_IRQ_MASK)
                irq_mask <= pwdata[IRQ_W-1:0];
            o_irq <= |(irq_status & irq_mask);
        end
    end

endmodule // host_processor_port

//--- rtl/host_port_pkg.sv
// Functional notes
// - Bus-style select low: strobe/acknowledge; high: byte-enable/wait.
// - Address bus is 19 bits in 32-bit mode, 17 bits in 16-bit mode; the code decodes A18-A1, 18 bits, in 16-bit mode.
// - Strobe style 32-bit: size lines give the transfer size and byte lanes.
// - Strobe style 16-bit: active-low size0 strobes byte D7-0, size1 D15-8.
// - Byte-enable/wait mode: size lines are active-low byte enables 0 and 1.
// - Device reset input low resets asynchronously; high runs normally.
// - Host reads and writes internal registers and internal memory.
// - Host writes connection memory; enabled channels send that message data.
// - Access happens only while chip select and data strobe are both low.
// - Read/write high reads, low writes; data bus direction follows it.
// - Invalid address drives bus error; strobe style then withholds ack.
// - Byte-enable style drives wait low in access, rises on completion.
package host_port_pkg;

    // ----------------------------------------------------------------
    // Widths and modes
    // ----------------------------------------------------------------
    localparam int          ADDR_W           = 19;
    localparam int          DATA_W           = 32;
    localparam int          WORD_W           = 17;
    localparam int          SYNC_W           = 58;
    localparam logic        STYLE_STROBE     = 1'b0;
    localparam logic        WIDTH_32         = 1'b0;
    localparam logic [1:0]  SIZE_LONG        = 2'h0;
    localparam logic [1:0]  SIZE_BYTE        = 2'h1;
    localparam logic [1:0]  SIZE_WORD        = 2'h2;
    localparam logic [1:0]  SIZE_TRIPLE      = 2'h3;

    // ----------------------------------------------------------------
    // Host port map, in 32-bit word indexes
    // ----------------------------------------------------------------
    localparam logic [16:0] HOST_CTRL_WORD    = 17'h00000;
    localparam logic [16:0] HOST_STATUS_WORD  = 17'h00001;
    localparam logic [16:0] HOST_SCRATCH_WORD = 17'h00002;
    localparam logic [16:0] CMEM_BASE_WORD    = 17'h04000;
    localparam int          CMEM_AW           = 6;
    localparam int          CMEM_DEPTH        = 64;
    localparam int          MSG_EN_BIT        = 31;
    localparam int          MSG_W             = 8;

    // ----------------------------------------------------------------
    // APB map and fields
    // ----------------------------------------------------------------
    localparam int          APB_AW            = 12;
    localparam logic [11:0] APB_CTRL          = 12'h000;
    localparam logic [11:0] APB_STATUS        = 12'h004;
    localparam logic [11:0] APB_IRQ_STATUS    = 12'h008;
    localparam logic [11:0] APB_IRQ_MASK      = 12'h00C;
    localparam int          CTRL_MSG_EN_BIT   = 0;
    localparam logic [31:0] CTRL_RESET        = 32'h00000000;
    localparam int          IRQ_W             = 3;
    localparam int          IRQ_WR_BIT        = 0;
    localparam int          IRQ_RD_BIT        = 1;
    localparam int          IRQ_BUS_ERROR_N_BIT      = 2;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_ACCESS  = 2'b01,
        ST_RESPOND = 2'b10
    } host_state_t;

endpackage

//--- rtl/lane_if.sv
`timescale 1ns/1ps
interface lane_if;
    logic        style;
    logic        narrow;
    logic [1:0]  size_lines;
    logic [1:0]  addr_low;
    logic [3:0]  lane_en;

    modport src (output style, output narrow, output size_lines,
                 output addr_low, input lane_en);
    modport dec (input style, input narrow, input size_lines,
                 input addr_low, output lane_en);
endinterface

//--- rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             i_clk,
    input  wire logic [WIDTH-1:0] i_pin,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage1;

    // ----------------------------------------------------------------
    // Two flops per bit; nothing else reads the first stage
    // ----------------------------------------------------------------
    for (genvar g = 0; g < WIDTH; g++)
    begin : g_bit
        always_ff @(posedge i_clk)
        begin
            stage1[g] <= i_pin[g];
            o_sync[g] <= stage1[g];
        end
    end
endmodule // pin_sync

//--- rtl/lane_decode.sv
`timescale 1ns/1ps
module lane_decode
    import host_port_pkg::*;
(
    lane_if.dec lanes
);
    logic [3:0] size_mask;
    logic [7:0] size_shift;
    logic [1:0] pair;
    logic [3:0] intel32;

    // ----------------------------------------------------------------
    // Byte lane selection per bus style and width
    // ----------------------------------------------------------------
    assign size_mask  = (lanes.size_lines == SIZE_BYTE)   ? 4'h1 :
                        (lanes.size_lines == SIZE_WORD)   ? 4'h3 :
                        (lanes.size_lines == SIZE_TRIPLE) ? 4'h7 :
                                                            4'hF;
    assign size_shift = {4'h0, size_mask} << lanes.addr_low;
    assign pair       = ~lanes.size_lines;
    // A1 and A0 serve as the upper byte enables in 32-bit enable mode
    assign intel32    = {~lanes.addr_low, pair};
    assign lanes.lane_en =
        (lanes.narrow != WIDTH_32)  ? (lanes.addr_low[1] ?
                                       {pair, 2'h0} : {2'h0, pair}) :
        (lanes.style == STYLE_STROBE) ? size_shift[3:0] :
                                        intel32;
endmodule // lane_decode

//--- verification/host_port_chk.sv
`timescale 1ns/1ps
module host_port_chk
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_device_reset_n,
    input wire logic i_bus_style_select,
    input wire logic i_cs_n,
    input wire logic i_data_strobe_n,
    input wire logic i_rw,
    input wire logic o_data_oe_n,
    input wire logic o_transfer_ack_n,
    input wire logic o_transfer_ack_oe_n,
    input wire logic o_bus_error_n,
    input wire logic o_bus_error_oe_n,
    input wire logic o_wait_n,
    input wire logic o_wait_oe_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr
);
    // ------------------------------------------------
    // Port protocol
    // ------------------------------------------------
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    style_ack_a: assert property (i_bus_style_select |->
        o_transfer_ack_oe_n) else $error("ack driven in wait style");
    style_wait_a: assert property (!i_bus_style_select |-> o_wait_oe_n)
        else $error("wait driven in strobe style");
    ack_strobe_a: assert property ($fell(o_transfer_ack_n) |->
        !i_cs_n && !i_data_strobe_n) else $error("ack without strobes");
    read_dir_a: assert property (!o_data_oe_n |-> i_rw)
        else $error("data driven on write");
    bus_error_n_noack_a: assert property (!o_bus_error_n &&
        !o_bus_error_oe_n && !i_bus_style_select |->
        o_transfer_ack_n || o_transfer_ack_oe_n)
        else $error("ack with bus error");
    wait_done_a: assert property ($fell(o_wait_n) |-> ##[1:3] o_wait_n)
        else $error("wait never completes");
    dev_reset_a: assert property (!i_device_reset_n [*2] |=>
        o_data_oe_n && o_transfer_ack_oe_n && o_wait_oe_n && o_bus_error_oe_n)
        else $error("pins driven in device reset");
    apb_ready_a: assert property (psel && penable && !pready |=> pready)
        else $error("late pready");
    apb_pulse_a: assert property (pready |=> !pready)
        else $error("pready too long");
    cover property ($fell(o_transfer_ack_n));
    cover property ($rose(o_wait_n));
    cover property (!o_bus_error_n && !o_bus_error_oe_n);
    cover property (pready && pslverr);
endmodule // host_port_chk

//--- verification/host_model.sv
`timescale 1ns/1ps
module host_model
(
    input  wire logic        i_clk,
    input  wire logic        i_style,
    input  wire logic        i_ack_n,
    input  wire logic        i_bus_error_n_n,
    input  wire logic        i_wait_n,
    input  wire logic [31:0] i_rdata,
    output logic             o_cs_n,
    output logic             o_ds_n,
    output logic             o_rw,
    output logic [18:0]      o_addr,
    output logic [1:0]       o_size,
    output logic [31:0]      o_data
);
    // ------------------------------------------------
    // One access, held until the answer
    // ------------------------------------------------
    initial
    begin
        o_cs_n = 1'b1;
        o_ds_n = 1'b1;
        o_rw = 1'b1;
        o_addr = '0;
        o_size = 2'h0;
        o_data = '0;
    end
    task automatic xfer(input logic rw, input logic [18:0] a,
        input logic [1:0] sz, input logic [31:0] wd,
        output logic [31:0] rd, output logic be, output logic to);
        int n;
        logic seen;
        be = 1'b0;
        to = 1'b1;
        seen = 1'b0;
        rd = '0;
        @(posedge i_clk);
        o_rw <= rw;
        o_addr <= a;
        o_size <= sz;
        o_data <= rw ? ~o_data : wd;
        o_cs_n <= 1'b0;
        o_ds_n <= 1'b0;
        for (n = 0; n < 40 && to; n++)
        begin
            @(posedge i_clk);
            if (!i_bus_error_n_n) be = 1'b1;
            if (!i_wait_n) seen = 1'b1;
            // Wait style ends on the rising wait edge only
            if (i_style ? seen && i_wait_n : !i_ack_n || !i_bus_error_n_n)
            begin
                to = 1'b0;
                rd = i_rdata;
            end
        end
        o_cs_n <= 1'b1;
        o_ds_n <= 1'b1;
        o_data <= ~o_data;
        repeat (5) @(posedge i_clk);
    endtask
endmodule // host_model

//--- verification/host_processor_port_tb_top.sv
`timescale 1ns/1ps
module host_processor_port_tb_top import host_port_pkg::*;;
    localparam logic [18:0] SCR = {HOST_SCRATCH_WORD, 2'b00};
    logic        clk = 1'b0, rst_n = 1'b0, dev_n = 1'b0, st = 1'b0;
    logic        nw = 1'b0, psel = 1'b0, pen = 1'b0, device_reset_n = 1'b0;
    logic [11:0] pad = '0;
    logic [31:0] pwd = '0, prd, od, exp, rd, hd;
    logic        prdy, perr, pe, irq, mv, doe, ack, aoe, ber, boe, wt, woe;
    logic        cs_n, ds_n, rw, be, to;
    logic [18:0] adr;
    logic [1:0]  sz, s, a;
    logic [5:0]  mch;
    logic [7:0]  mdat;
    int          miscompares = 0, check_count = 0, seed = 92, i, k;
    always #12.5 clk = ~clk;
    host_processor_port i_host_processor_port (.i_clk(clk), .i_reset_n(rst_n),
        .i_device_reset_n(dev_n), .i_bus_style_select(st),
        .i_narrow_bus_select(nw), .i_cs_n(cs_n), .i_data_strobe_n(ds_n),
        .i_rw(rw), .i_addr(adr), .i_xfer_width_lines(sz), .i_data(od),
        .o_data(hd), .o_data_oe_n(doe), .o_transfer_ack_n(ack),
        .o_transfer_ack_oe_n(aoe), .o_bus_error_n(ber),
        .o_bus_error_oe_n(boe), .o_wait_n(wt), .o_wait_oe_n(woe),
        .psel(psel), .penable(pen), .pwrite(device_reset_n), .paddr(pad),
        .pwdata(pwd), .prdata(prd), .pready(prdy), .pslverr(perr),
        .o_irq(irq), .o_msg_valid(mv), .o_msg_channel(mch),
        .o_msg_data(mdat));
    // Released pins float high through the pull-ups
    host_model i_host_model (.i_clk(clk), .i_style(st), .i_ack_n(aoe | ack),
        .i_bus_error_n_n(boe | ber), .i_wait_n(woe | wt), .i_rdata(hd),
        .o_cs_n(cs_n), .o_ds_n(ds_n), .o_rw(rw), .o_addr(adr),
        .o_size(sz), .o_data(od));
    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, v);
        check_count++;
        if (v !== e)
        begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", nm, e, v);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] ad,
        input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        device_reset_n <= w;
        pad <= ad;
        pwd <= wd;
        @(posedge clk);
        pen <= 1'b1;
        for (n = 0; n < 20 && prdy !== 1'b1; n++) @(posedge clk);
        if (n == 20) begin miscompares++; test_done; end
        rd = prd;
        pe = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic hx(input logic r, input logic [18:0] ad,
        input logic [1:0] sw, input logic [31:0] w);
        i_host_model.xfer(r, ad, sw, w, rd, be, to);
        if (to) begin miscompares++; test_done; end
    endtask
    function automatic logic [31:0] lmask(input logic [1:0] sw, aw);
        logic [3:0] m;
        m = 4'(((1 << (sw == SIZE_LONG ? 4 : sw)) - 1) << aw);
        if (nw) m = aw[1] ? {~sw, 2'b00} : {2'b00, ~sw};
        else if (st) m = {~aw[1], ~aw[0], ~sw[1], ~sw[0]};
        return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
    endfunction
    task automatic hw(input logic [1:0] aw, sw, input logic [31:0] w);
        hx(1'b0, SCR | aw, sw, w);
        w = nw ? {2{w[15:0]}} : w;
        exp = (exp & ~lmask(sw, aw)) | (w & lmask(sw, aw));
    endtask
    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        dev_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'b0, APB_CTRL, 32'h0);
        chk("ctrl", CTRL_RESET, rd);
        apb(1'b0, 12'h010, 32'h0);
        chk("slverr", 32'h1, {31'h0, pe});
        hx(1'b0, {CMEM_BASE_WORD + 17'h5, 2'b00}, SIZE_LONG, 32'h800000A5);
        hx(1'b1, {CMEM_BASE_WORD + 17'h5, 2'b00}, SIZE_LONG, 32'h0);
        chk("cmem", 32'h800000A5, rd);
        chk("cmem_bus_error_n", 32'h0, {31'h0, be});
        apb(1'b1, APB_CTRL, 32'h1);
        for (i = 0; i < 200 && !(mv === 1'b1 && mch === 6'h5); i++)
            @(posedge clk);
        if (i == 200) begin miscompares++; test_done; end
        chk("msg", 32'hA5, {24'h0, mdat});
        for (k = 0; k < 4; k++)
        begin
            dev_n <= 1'b0;
            st <= k[0];
            nw <= k[1];
            repeat (4) @(posedge clk);
            dev_n <= 1'b1;
            repeat (4) @(posedge clk);
            apb(1'b0, APB_STATUS, 32'h0);
            chk("mode", k, {30'h0, rd[2:1]});
            hw(2'h0, SIZE_LONG, $random(seed));
            if (nw) hw(2'h2, SIZE_LONG, $random(seed));
            for (i = 0; i < 4; i++)
            begin
                s = 2'($random(seed));
                a = 2'($random(seed));
                if (!st && !nw && a + (s == 2'h0 ? 4 : s) > 4) a = 2'h0;
                hw(a, s, $random(seed));
            end
            hx(1'b1, SCR, SIZE_LONG, 32'h0);
            chk("scr", nw ? {16'h0, exp[15:0]} : exp,
                nw ? {16'h0, rd[15:0]} : rd);
            if (nw) hx(1'b1, SCR | 19'h2, SIZE_LONG, 32'h0);
            if (nw) chk("scr_hi", exp[31:16], rd[15:0]);
            hx(1'b0, 19'h400, SIZE_LONG, 32'h0);
            chk("bus_error_n", 32'h1, {31'h0, be});
        end
        apb(1'b1, APB_IRQ_MASK, 32'h1);
        apb(1'b0, APB_IRQ_STATUS, 32'h0);
        chk("irq_st", 32'h7, rd & 32'h7);
        chk("irq_on", 32'h1, {31'h0, irq});
        apb(1'b1, APB_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq_mask", 32'h0, {31'h0, irq});
        apb(1'b1, APB_IRQ_STATUS, 32'h7);
        apb(1'b1, APB_IRQ_MASK, 32'h7);
        repeat (2) @(posedge clk);
        chk("irq_clr", 32'h0, {31'h0, irq});
        test_done;
    end
endmodule // host_processor_port_tb_top
bind host_processor_port host_port_chk i_host_port_chk (.*);
